// >>> shared/eas_defs.svh
// constants for the serial memory slave addressing front end
`ifndef EAS_DEFS_SVH
`define EAS_DEFS_SVH

// control byte field positions
`define EAS_CODE_MSB 7
`define EAS_CODE_LSB 4
`define EAS_BLK_BIT 3
`define EAS_CS_HI_BIT 2
`define EAS_CS_LO_BIT 1
`define EAS_RW_BIT 0

// fixed device-type code
`define EAS_CTRL_CODE 4'ha

// bit counter landmarks: ack slot and end of ack clock
`define EAS_CNT_ACK 4'h8
`define EAS_CNT_DONE 4'h9

// reset values
`define EAS_RST_BYTE 8'h00
`define EAS_RST_WORD 16'h0000

// transmit hold after a falling clock edge
`define EAS_CLK_PERIOD_NS 10
`define EAS_TX_HOLD_NS 300
`define EAS_TX_HOLD_CYC ((`EAS_TX_HOLD_NS + `EAS_CLK_PERIOD_NS - 1) / `EAS_CLK_PERIOD_NS)

`endif

// >>> shared/eas_pkg.sv
// types for the serial memory slave addressing front end
package eas_pkg;

	// one-hot protocol states
	typedef enum logic [6:0] {
		EAS_ST_IDLE    = 7'h01,
		EAS_ST_CTRL    = 7'h02,
		EAS_ST_ADDR_HI = 7'h04,
		EAS_ST_ADDR_LO = 7'h08,
		EAS_ST_WDATA   = 7'h10,
		EAS_ST_RDATA   = 7'h20,
		EAS_ST_IGNORE  = 7'h40
	} eas_state_t;

	// strap and protect pins
	typedef struct packed {
		logic fixed_select_strap;
		logic chip_select_strap_high;
		logic chip_select_strap_low;
		logic write_inhibit;
	} eas_pins_t;

	// decoded access address
	typedef struct packed {
		logic        top_array_address_bit;
		logic [1:0]  chip_select;
		logic [15:0] word;
	} eas_addr_t;

	// whole state of the slave
	typedef struct packed {
		logic       scl_m;
		logic       scl_s;
		logic       scl_p;
		logic       sda_m;
		logic       sda_s;
		logic       sda_p;
		eas_pins_t  pins_m;
		eas_pins_t  pins_s;
		eas_state_t st;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] tx;
		logic       want;
		logic       oe;
		logic       sda_o;
		logic [5:0] hold;
		logic [7:0] ctrl;
		logic [7:0] last_ctrl;
		logic       wr_seen;
		eas_addr_t  addr;
		logic       addr_vld;
		logic       head_v;
		logic [7:0] head_d;
		logic       spare_v;
		logic [7:0] spare_d;
		logic       rd_next;
		logic       wr_start;
		logic       sel;
		logic       rd_mode;
	} eas_regs_t;

endpackage

// >>> design/eas_slave.sv
// two-wire serial memory slave: conditions, bit shifting, ack and control byte decode
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`include "eas_defs.svh"

module eas_slave (
	// clock and reset
	input  wire logic               i_core_clk,
	input  wire logic               i_reset_n,
	// two-wire bus pins
	input  wire logic               i_scl,
	input  wire logic               i_sda,
	output logic                    o_sda_o,
	output logic                    o_sda_oe,
	// straps and write protect
	input  wire eas_pkg::eas_pins_t i_pins,
	// write engine side
	input  wire logic               i_prog_busy,
	output logic                    o_write_start,
	output eas_pkg::eas_addr_t      o_addr,
	output logic                    o_addr_valid,
	// received data stream
	output logic [7:0]              o_wr_data,
	output logic                    o_wr_valid,
	input  wire logic               i_wr_ready,
	// read data source
	input  wire logic [7:0]         i_rd_data,
	output logic                    o_rd_next,
	// status
	output logic                    o_selected,
	output logic                    o_read_mode
);
	import eas_pkg::*;

	eas_regs_t s;
	eas_regs_t d;

	// ****************************************************************
	// bus events
	// ****************************************************************
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic id_match;
	logic busy_hit;
	logic active;
	logic pop;

	// edges only ever look at the second and third flops
	assign scl_rise   = s.scl_s & ~s.scl_p;
	assign scl_fall   = ~s.scl_s & s.scl_p;
	assign start_cond = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s;
	assign stop_cond  = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s;

	// control byte decode against code and straps
	assign id_match = (s.shift[`EAS_CODE_MSB:`EAS_CODE_LSB] == `EAS_CTRL_CODE)
		& s.pins_s.fixed_select_strap
		& (s.shift[`EAS_CS_HI_BIT] == s.pins_s.chip_select_strap_high)
		& (s.shift[`EAS_CS_LO_BIT] == s.pins_s.chip_select_strap_low);
	// polling with the control byte of the running write gets no ack
	assign busy_hit = i_prog_busy & (s.shift == s.last_ctrl);

	assign active = (s.st == EAS_ST_CTRL) | (s.st == EAS_ST_ADDR_HI) | (s.st == EAS_ST_ADDR_LO)
		| (s.st == EAS_ST_WDATA) | (s.st == EAS_ST_RDATA);
	assign pop = s.head_v & i_wr_ready;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		d = s;
		d.addr_vld = 1'b0;
		d.rd_next  = 1'b0;
		d.wr_start = 1'b0;
		d.sda_o    = 1'b0;
		// two flops on every pin before use
		d.scl_m  = i_scl;
		d.scl_s  = s.scl_m;
		d.scl_p  = s.scl_s;
		d.sda_m  = i_sda;
		d.sda_s  = s.sda_m;
		d.sda_p  = s.sda_s;
		d.pins_m = i_pins;
		d.pins_s = s.pins_m;

		// output buffer drain side
		if (pop) begin
			d.head_v  = s.spare_v;
			d.head_d  = s.spare_d;
			d.spare_v = 1'b0;
		end

		if (start_cond) begin
			// repeated start drops a pending write without starting it
			d.st      = EAS_ST_CTRL;
			d.cnt     = 4'h0;
			d.want    = 1'b0;
			d.wr_seen = 1'b0;
			d.sel     = 1'b0;
		end else if (stop_cond) begin
			if (s.wr_seen && !s.pins_s.write_inhibit) begin
				d.wr_start  = 1'b1;
				d.last_ctrl = s.ctrl;
			end
			d.st      = EAS_ST_IDLE;
			d.want    = 1'b0;
			d.wr_seen = 1'b0;
			d.sel     = 1'b0;
		end else if (active && scl_rise) begin
			if (s.cnt < `EAS_CNT_ACK) begin
				d.shift = {s.shift[6:0], s.sda_s};
				d.cnt   = s.cnt + 4'h1;
			end else begin
				d.cnt = `EAS_CNT_DONE;
				// master ack slot of a read byte; own ack is not sampled
				if (s.st == EAS_ST_RDATA && !s.want) begin
					if (s.sda_s) begin
						d.st = EAS_ST_IGNORE;
					end else begin
						d.rd_next = 1'b1;
					end
				end
			end
		end else if (active && scl_fall) begin
			if (s.cnt == `EAS_CNT_ACK) begin
				d.want = 1'b1;
				case (s.st)
					EAS_ST_CTRL: begin
						if (id_match && !busy_hit) begin
							d.sel     = 1'b1;
							d.ctrl    = s.shift;
							d.rd_mode = s.shift[`EAS_RW_BIT];
							d.addr.top_array_address_bit = s.shift[`EAS_BLK_BIT];
							d.addr.chip_select = s.shift[`EAS_CS_HI_BIT:`EAS_CS_LO_BIT];
							// direction bit picks the next phase
							d.st = s.shift[`EAS_RW_BIT] ? EAS_ST_RDATA : EAS_ST_ADDR_HI;
						end else begin
							d.want = 1'b0;
							d.st   = EAS_ST_IGNORE;
						end
					end
					EAS_ST_ADDR_HI: begin
						d.addr.word[15:8] = s.shift;
						d.st = EAS_ST_ADDR_LO;
					end
					EAS_ST_ADDR_LO: begin
						d.addr.word[7:0] = s.shift;
						d.addr_vld = 1'b1;
						d.st = EAS_ST_WDATA;
					end
					EAS_ST_WDATA: begin
						// a full buffer refuses the byte rather than lose it
						if (!s.spare_v) begin
							d.wr_seen = 1'b1;
							if (!s.pins_s.write_inhibit) begin
								if (!d.head_v) begin
									d.head_v = 1'b1;
									d.head_d = s.shift;
								end else begin
									d.spare_v = 1'b1;
									d.spare_d = s.shift;
								end
							end
						end else begin
							d.want = 1'b0;
							d.st   = EAS_ST_IGNORE;
						end
					end
					EAS_ST_RDATA: begin
						d.want = 1'b0;
					end
					default: begin
						d.want = 1'b0;
					end
				endcase
			end else if (s.cnt == `EAS_CNT_DONE) begin
				d.cnt  = 4'h0;
				d.want = 1'b0;
				if (s.st == EAS_ST_RDATA) begin
					d.tx   = i_rd_data;
					d.want = ~i_rd_data[7];
				end
			end else if (s.st == EAS_ST_RDATA && s.cnt != 4'h0) begin
				d.tx   = {s.tx[6:0], 1'b0};
				d.want = ~s.tx[6];
			end
		end

		// output hold: change only with clock low and after the hold time
		if (scl_fall) begin
			d.hold = 6'(`EAS_TX_HOLD_CYC);
		end else if (s.hold != 6'h00) begin
			d.hold = s.hold - 6'h01;
		end
		// the fall edge only arms the hold, so the line never moves on the edge itself
		if (!s.scl_s && !scl_fall && s.hold == 6'h00) begin
			d.oe = s.want;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s <= '{
				scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
				sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
				pins_m: '0, pins_s: '0,
				st: EAS_ST_IDLE, cnt: 4'h0,
				shift: `EAS_RST_BYTE, tx: `EAS_RST_BYTE,
				want: 1'b0, oe: 1'b0, sda_o: 1'b0, hold: 6'h00,
				ctrl: `EAS_RST_BYTE, last_ctrl: `EAS_RST_BYTE, wr_seen: 1'b0,
				addr: '0, addr_vld: 1'b0,
				head_v: 1'b0, head_d: `EAS_RST_BYTE,
				spare_v: 1'b0, spare_d: `EAS_RST_BYTE,
				rd_next: 1'b0, wr_start: 1'b0, sel: 1'b0, rd_mode: 1'b0
			};
		end else begin
			s <= d;
		end
	end

	// outputs straight from the state register
	assign o_sda_o       = s.sda_o;
	assign o_sda_oe      = s.oe;
	assign o_write_start = s.wr_start;
	assign o_addr        = s.addr;
	assign o_addr_valid  = s.addr_vld;
	assign o_wr_data     = s.head_d;
	assign o_wr_valid    = s.head_v;
	assign o_rd_next     = s.rd_next;
	assign o_selected    = s.sel;
	assign o_read_mode   = s.rd_mode;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_ack_slot(eas_state_t st_x);
		(s.st == st_x) && scl_fall && (s.cnt == `EAS_CNT_ACK) && !start_cond && !stop_cond;
	endsequence

	property p_never_high;
		o_sda_o == 1'b0;
	endproperty
	a_never_high: assert property (p_never_high) else $error("data line driven high");

	property p_change_low;
		$changed(o_sda_oe) |-> !$past(s.scl_s);
	endproperty
	a_change_low: assert property (p_change_low) else $error("data changed with clock high");

	property p_hold_time;
		scl_fall |=> $stable(o_sda_oe) [*8];
	endproperty
	a_hold_time: assert property (p_hold_time) else $error("data changed inside hold time");

	property p_start;
		start_cond |=> (s.st == EAS_ST_CTRL) && (s.cnt == 4'h0) && !s.want;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

	property p_stop;
		stop_cond |=> (s.st == EAS_ST_IDLE) && !s.sel;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");

	property p_ack_match;
		s_ack_slot(EAS_ST_CTRL) and (id_match && !busy_hit) |=> s.want && s.sel
			&& (s.st == ($past(s.shift[0]) ? EAS_ST_RDATA : EAS_ST_ADDR_HI));
	endproperty
	a_ack_match: assert property (p_ack_match) else $error("matching control byte mishandled");

	property p_mismatch;
		s_ack_slot(EAS_ST_CTRL) and !id_match |=> !s.want && (s.st == EAS_ST_IGNORE);
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatch was acknowledged");

	property p_busy;
		s_ack_slot(EAS_ST_CTRL) and busy_hit |=> !s.want ##1 !s.want;
	endproperty
	a_busy: assert property (p_busy) else $error("ack given while busy");

	property p_addr_order;
		s_ack_slot(EAS_ST_ADDR_HI) |=> (s.st == EAS_ST_ADDR_LO) && (s.addr.word[15:8] == $past(s.shift));
	endproperty
	a_addr_order: assert property (p_addr_order) else $error("high address byte misplaced");

	property p_inhibit;
		stop_cond && s.pins_s.write_inhibit |=> !o_write_start;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("write started while inhibited");

	property p_bit_count;
		active && scl_rise && (s.cnt < `EAS_CNT_ACK) && !start_cond |=> s.cnt == $past(s.cnt) + 4'h1;
	endproperty
	a_bit_count: assert property (p_bit_count) else $error("bit count slipped");

	// block select lands in the top address bit, ignored frames and read acks stay released
	property p_block_sel;
		s_ack_slot(EAS_ST_CTRL) and (id_match && !busy_hit)
			|=> o_addr.top_array_address_bit == $past(s.shift[`EAS_BLK_BIT]);
	endproperty
	a_block_sel: assert property (p_block_sel) else $error("block select misplaced");

	property p_ignore_quiet;
		(s.st == EAS_ST_IGNORE) |-> !s.want;
	endproperty
	a_ignore_quiet: assert property (p_ignore_quiet) else $error("ignored frame driven");

	property p_rd_release;
		s_ack_slot(EAS_ST_RDATA) |=> !s.want;
	endproperty
	a_rd_release: assert property (p_rd_release) else $error("read ack slot not released");

endmodule // eas_slave

// >>> test/eas_master.sv
// two-wire bus master model for the slave bench
`timescale 1ns/1ps

module eas_master (
	// core clock and resolved data line
	input  wire logic i_core_clk,
	input  wire logic i_sda,
	// bus clock and data pull-down
	output logic      o_scl,
	output logic      o_sda_oe
);
	// idle bus, both lines high; clock stands still between frames
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end

	// whole core cycles plus the bench input skew
	task automatic wt(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask

	// data falls while clock high, also a repeated start
	task automatic start();
		o_sda_oe = 1'b0;
		wt(40);
		o_scl = 1'b1;
		wt(8);
		o_sda_oe = 1'b1;
		wt(8);
		o_scl = 1'b0;
	endtask

	// data rises while clock high
	task automatic stop();
		wt(4);
		o_sda_oe = 1'b1;
		wt(36);
		o_scl = 1'b1;
		wt(8);
		o_sda_oe = 1'b0;
		wt(40);
	endtask

	// low phase stretched past the slave's 300 ns drive hold
	task automatic bitx(input logic b, output logic s);
		wt(4);
		o_sda_oe = !b;
		wt(36);
		o_scl = 1'b1;
		wt(4);
		s = i_sda;
		wt(4);
		o_scl = 1'b0;
	endtask

	// eight bits msb first, then the ack clock carrying n9
	task automatic xfer(input logic [7:0] d, input logic n9, output logic [7:0] r,
		output logic a);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r[i]);
		end
		bitx(n9, a);
	endtask
endmodule // eas_master

// >>> test/tb.sv
// self-checking bench for the two-wire slave front end
`timescale 1ns/1ps

module tb;
	import eas_pkg::*;
	// bench nets and counters
	logic       clk;
	logic       rst_n;
	logic       busy;
	logic       rdy;
	logic       scl, m_oe, sda, sda_o, sda_oe, prev_oe;
	logic       wvld, wstart, avld, rnext, seld, rmode, a;
	logic [7:0] rd_data, wdata, r;
	eas_pins_t  pins;
	eas_addr_t  addr;
	int         ws_n, av_n, rn_n, wv_n, ws0, wv0, error_cnt, total_checks;

	// released line floats to the pull-up
	assign sda = !(m_oe || (sda_oe && !sda_o));
	always #5 clk = ~clk;

	eas_slave u_dut (
		.i_core_clk    (clk),
		.i_reset_n     (rst_n),
		.i_scl         (scl),
		.i_sda         (sda),
		.o_sda_o       (sda_o),
		.o_sda_oe      (sda_oe),
		.i_pins        (pins),
		.i_prog_busy   (busy),
		.o_write_start (wstart),
		.o_addr        (addr),
		.o_addr_valid  (avld),
		.o_wr_data     (wdata),
		.o_wr_valid    (wvld),
		.i_wr_ready    (rdy),
		.i_rd_data     (rd_data),
		.o_rd_next     (rnext),
		.o_selected    (seld),
		.o_read_mode   (rmode)
	);

	eas_master u_mst (
		.i_core_clk (clk),
		.i_sda      (sda),
		.o_scl      (scl),
		.o_sda_oe   (m_oe)
	);

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// pulse counters and wire watch, on the quiet edge
	always @(negedge clk) begin
		ws_n += (wstart === 1'b1);
		av_n += (avld === 1'b1);
		rn_n += (rnext === 1'b1);
		wv_n += (wvld === 1'b1 && rdy);
		if (sda_oe === 1'b1) check("sda_o", sda_o, 0);
		if (scl && sda_oe !== prev_oe) check("oe_at_high", 1, 0);
		prev_oe = sda_oe;
	end

	// read source advances when the master asks for more
	always @(posedge clk) if (rnext === 1'b1) #1 rd_data = ~rd_data;

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_write();
		u_mst.start();
		u_mst.xfer(8'hac, 1'b1, r, a);
		check("ctrl_ack", a, 0);
		check("selected", seld, 1);
		check("read_mode", rmode, 0);
		u_mst.xfer(8'h12, 1'b1, r, a);
		u_mst.xfer(8'h34, 1'b1, r, a);
		check("addr_pulse", av_n, 1);
		check("addr", addr, {1'b1, 2'b10, 16'h1234});
		u_mst.xfer(8'h5a, 1'b1, r, a);
		u_mst.xfer(8'hc3, 1'b1, r, a);
		check("data_ack", a, 0);
		u_mst.xfer(8'h99, 1'b1, r, a);
		check("full_nack", a, 1);
		check("head", wdata, 8'h5a);
		rdy = 1'b1;
		u_mst.wt(1);
		rdy = 1'b0;
		u_mst.wt(1);
		check("next", wdata, 8'hc3);
		u_mst.stop();
		rdy = 1'b1;
		u_mst.wt(4);
		check("drained", wvld, 0);
		$display("t_write done");
	endtask

	// one write, committed or held back by write inhibit as wi selects
	task automatic t_commit(input logic wi);
		pins.write_inhibit = wi;
		ws0 = ws_n;
		wv0 = wv_n;
		u_mst.start();
		u_mst.xfer(8'hac, 1'b1, r, a);
		u_mst.xfer(8'h00, 1'b1, r, a);
		u_mst.xfer(8'h10, 1'b1, r, a);
		u_mst.xfer(8'h77, 1'b1, r, a);
		check("wr_ack", a, 0);
		u_mst.stop();
		u_mst.wt(10);
		check("write_start", ws_n - ws0, !wi);
		check("pushed", wv_n - wv0, !wi);
		pins.write_inhibit = 1'b0;
		$display("t_commit done");
	endtask

	// entries: fixed/high/low straps, control byte, expected ack bit
	task automatic t_select();
		logic [11:0] tbl [7] = '{12'hd48, 12'hd41, 12'hd45, 12'hd4d, 12'hc49, 12'h549,
			12'hb44};
		for (int k = 0; k < 7; k++) begin
			pins[3:1] = tbl[k][11:9];
			u_mst.wt(10);
			u_mst.start();
			u_mst.xfer(tbl[k][8:1], 1'b1, r, a);
			check("sel_ack", a, tbl[k][0]);
			check("selected", seld, !tbl[k][0]);
			u_mst.xfer(8'h00, 1'b1, r, a);
			check("after", a, tbl[k][0]);
			u_mst.stop();
		end
		pins = 4'b1100;
		$display("t_select done");
	endtask

	task automatic t_busy();
		busy = 1'b1;
		u_mst.start();
		u_mst.xfer(8'hac, 1'b1, r, a);
		check("busy_same", a, 1);
		u_mst.stop();
		u_mst.start();
		u_mst.xfer(8'ha4, 1'b1, r, a);
		check("busy_other", a, 0);
		u_mst.stop();
		busy = 1'b0;
		$display("t_busy done");
	endtask

	task automatic t_read();
		ws0 = rn_n;
		u_mst.start();
		u_mst.xfer(8'had, 1'b1, r, a);
		check("rd_ack", a, 0);
		check("read_mode", rmode, 1);
		u_mst.xfer(8'hff, 1'b0, r, a);
		check("rd_byte0", r, 8'ha5);
		check("rd_next", rn_n - ws0, 1);
		u_mst.xfer(8'hff, 1'b1, r, a);
		check("rd_byte1", r, 8'h5a);
		u_mst.wt(40);
		check("released", sda_oe, 0);
		u_mst.stop();
		check("deselect", seld, 0);
		$display("t_read done");
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		busy = 1'b0;
		rdy = 1'b0;
		pins = 4'b1100;
		rd_data = 8'ha5;
		prev_oe = 1'b0;
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'b1;
		u_mst.wt(10);
		t_write();
		t_commit(1'b0);
		t_commit(1'b1);
		t_select();
		t_busy();
		t_read();
		end_sim();
	end

	// watchdog, well past the expected run of about 163 us
	initial begin
		#400us;
		check("watchdog", 1, 0);
		end_sim();
	end
endmodule // tb
